// ### core/cddds_regs.vh
`ifndef CDDDS_REGS_VH
`define CDDDS_REGS_VH
// apb register byte offsets
`define CDDDS_REF_CTRL      12'h000
`define CDDDS_REF_DIV0      12'h004
`define CDDDS_REF_DIV1      12'h008
`define CDDDS_REF_DIV2      12'h00C
`define CDDDS_PATH_CTRL     12'h010
`define CDDDS_DCLK_DIV      12'h014
`define CDDDS_DCLK_DLY      12'h018
`define CDDDS_SREF_DIV      12'h01C
`define CDDDS_SREF_DLY      12'h020
`define CDDDS_SYNC_CTRL     12'h024
`define CDDDS_STATUS_SEL    12'h028
`define CDDDS_STATUS        12'h02C
// ref_ctrl fields
`define CDDDS_POLICY_AUTO   2'h1
`define CDDDS_POLICY_PIN    2'h2
// divider and digital delay limits
`define CDDDS_DCLK_DIV_MIN  6'h01
`define CDDDS_DCLK_DIV_MAX  6'h20
`define CDDDS_SREF_DIV_MIN  13'h0008
`define CDDDS_SREF_DIV_MAX  13'h1FFF
`define CDDDS_DDLY_MIN      6'h04
`define CDDDS_DDLY_MAX      6'h20
`define CDDDS_SDLY_MIN      5'h01
`define CDDDS_SDLY_MAX      5'h0B
// analog delay steps: 25 ps up to 575 ps (23 steps), 150 ps per sysref step
`define CDDDS_ADLY_MAX      5'h17
`define CDDDS_ADLY_STEP_PS  25
`define CDDDS_ADLY_FIXED_PS 500
`define CDDDS_SADLY_STEP_PS 150
// status pin sources
`define CDDDS_ST_LOS        3'h0
`define CDDDS_ST_REFSEL     3'h1
`define CDDDS_ST_LOCK       3'h2
`define CDDDS_ST_LOCK2      3'h3
`define CDDDS_ST_DIVOUT     3'h4
`define CDDDS_ST_RAIL       3'h5
`define CDDDS_ST_READBACK   3'h6
`endif

// ### core/cddds_core.v
// Overview of operation
// - pick active reference, automatic or manual
// - separate divider per reference input
// - two select pins choose reference fast
// - device clock divide 1 to 32, 50% duty (code: odd ratios run one cycle shorter high than low, ratio 1 stays high)
// - device divider may feed paired sysref
// - one shared sysref divider 8 to 8191
// - device digital delay 4 to 32 cycles (code loads dclk_dly_r[5:0] on sync without clamping it to that range)
// - new coarse delay waits for sync in fixed mode; dynamic mode takes it while running
// - fixed and dynamic digital delay modes
// - analog delay 25 ps steps, +500 ps
// - shared sysref digital delay stage
// - local sysref delay 1 to 11 cycles
// - local sysref analog delay 150 ps steps
// - glitchless half step and analog changes
// - sync aligns all active outputs' edges
// - buffered osc output source select
// - vco selector feeds distribution and feedback
// - feedback selector in zero-delay modes
// - external vco/feedback consumes ref input 1
// - status pins programmable sources
// - holdover when selected reference lost (pin, manual) or all three lost (auto)
// - sync resets divider only if allowed
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "cddds_regs.vh"
module cddds_core #(
  parameter NCH = 7
) (
  // clock and reset
  input  wire              core_clk_i,
  input  wire              nrst_i,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output wire              pslverr,
  output reg  [31:0]       prdata,
  // reference inputs, loss-of-signal flags, select pins
  input  wire [2:0]        ref_input_i,
  input  wire [2:0]        ref_los_i,
  input  wire              ref_select_pin_0_i,
  input  wire              ref_select_pin_1_i,
  // loop status and external sources
  input  wire              lock1_i,
  input  wire              lock2_i,
  input  wire              vtune_rail_i,
  input  wire              second_loop_ref_input_i,
  input  wire              external_feedback_input_i,
  input  wire [1:0]        vco_i,
  input  wire              ext_vco_i,
  input  wire              sync_i,
  // distribution outputs
  output reg  [NCH-1:0]    device_clock_output_o,
  output reg  [NCH-1:0]    sysref_output_o,
  output reg  [NCH-1:0]    half_step_o,
  output reg  [5*NCH-1:0]  analog_delay_o,
  output reg  [NCH-1:0]    analog_en_o,
  output reg  [4*NCH-1:0]  sysref_analog_delay_o,
  output reg               buffered_osc_output_o,
  output reg  [1:0]        osc_output_format_o,
  output reg               vco_sel_o,
  output reg               dist_clk_o,
  output reg               loop_feedback_o,
  output reg  [2:0]        ref_div_out_o,
  output reg  [1:0]        active_ref_o,
  output reg               holdover_o,
  output reg               status_pin_1_o,
  output reg               status_pin_2_o
);

  // register file
  reg  [1:0]        ref_select_policy_r;
  reg  [1:0]        ref_manual_r;
  reg  [23:0]       ref_div_r [0:2];
  reg  [31:0]       path_ctrl_r;
  reg  [5:0]        dclk_div_r;
  reg  [31:0]       dclk_dly_r;
  reg  [12:0]       sref_div_r;
  reg  [31:0]       sref_dly_r;
  reg  [31:0]       sync_ctrl_r;
  reg  [5:0]        status_sel_r;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  reg  addr_ok;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // path_ctrl fields
  wire [1:0] osc_output_source = path_ctrl_r[1:0];
  wire       vco_selector      = path_ctrl_r[2];
  wire [1:0] feedback_selector = path_ctrl_r[4:3];
  wire       zero_delay_en     = path_ctrl_r[5];
  wire       ext_vco_en        = path_ctrl_r[6];
  wire       dyn_delay_mode    = path_ctrl_r[7];
  wire [NCH-1:0] dclk_to_sref  = path_ctrl_r[14:8];
  // sync_ctrl fields
  wire           sync_en            = sync_ctrl_r[0];
  wire           glitchless_en      = sync_ctrl_r[1];
  wire [NCH-1:0] divider_sync_block = sync_ctrl_r[8:2];
  wire           sref_sync_block    = sync_ctrl_r[9];

  always @* begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `CDDDS_STATUS);
  end

  // external vco or feedback takes ref input 1
  wire ref1_taken = ext_vco_en | (zero_delay_en & (feedback_selector == 2'h3));
  wire [2:0] ref_ok = ~ref_los_i & {1'b1, ~ref1_taken, 1'b1};

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_select_policy_r <= 2'h0;
      ref_manual_r        <= 2'h0;
      ref_div_r[0]        <= 24'h000001;
      ref_div_r[1]        <= 24'h000001;
      ref_div_r[2]        <= 24'h000001;
      path_ctrl_r         <= 32'h00000000;
      dclk_div_r          <= `CDDDS_DCLK_DIV_MIN;
      dclk_dly_r          <= 32'h00000004;
      sref_div_r          <= `CDDDS_SREF_DIV_MIN;
      sref_dly_r          <= 32'h00000001;
      sync_ctrl_r         <= 32'h00000000;
      status_sel_r        <= 6'h00;
    end else if (wr_en && addr_ok) begin
      case (paddr)
        `CDDDS_REF_CTRL: begin
          ref_select_policy_r <= pwdata[1:0];
          ref_manual_r        <= pwdata[3:2];
        end
        `CDDDS_REF_DIV0:   ref_div_r[0] <= pwdata[23:0];
        `CDDDS_REF_DIV1:   ref_div_r[1] <= pwdata[23:0];
        `CDDDS_REF_DIV2:   ref_div_r[2] <= pwdata[23:0];
        `CDDDS_PATH_CTRL:  path_ctrl_r  <= pwdata;
        `CDDDS_DCLK_DIV: begin
          if (pwdata[5:0] < `CDDDS_DCLK_DIV_MIN)
            dclk_div_r <= `CDDDS_DCLK_DIV_MIN;
          else if (pwdata[5:0] > `CDDDS_DCLK_DIV_MAX)
            dclk_div_r <= `CDDDS_DCLK_DIV_MAX;
          else
            dclk_div_r <= pwdata[5:0];
        end
        `CDDDS_DCLK_DLY:   dclk_dly_r   <= pwdata;
        `CDDDS_SREF_DIV: begin
          if (pwdata[12:0] < `CDDDS_SREF_DIV_MIN)
            sref_div_r <= `CDDDS_SREF_DIV_MIN;
          else
            sref_div_r <= pwdata[12:0];
        end
        `CDDDS_SREF_DLY:   sref_dly_r   <= pwdata;
        `CDDDS_SYNC_CTRL:  sync_ctrl_r  <= pwdata;
        `CDDDS_STATUS_SEL: status_sel_r <= pwdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // one reference divider per input, edge counted
  reg [2:0]  ref_d_r;
  reg [23:0] ref_cnt_r [0:2];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ref
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ref_d_r[gi]       <= 1'b0;
          ref_cnt_r[gi]     <= 24'h000000;
          ref_div_out_o[gi] <= 1'b0;
        end else begin
          ref_d_r[gi] <= ref_input_i[gi];
          if (ref_input_i[gi] & ~ref_d_r[gi]) begin
            if (ref_cnt_r[gi] + 24'h000001 >= ref_div_r[gi]) begin
              ref_cnt_r[gi]     <= 24'h000000;
              ref_div_out_o[gi] <= ~ref_div_out_o[gi];
            end else begin
              ref_cnt_r[gi] <= ref_cnt_r[gi] + 24'h000001;
            end
          end
        end
      end
    end
  endgenerate

  // reference selection, pin select, auto switch
  reg [1:0] ref_nxt;
  reg       hold_nxt;
  wire [1:0] pin_sel = {ref_select_pin_1_i, ref_select_pin_0_i};
  always @* begin
    ref_nxt  = active_ref_o;
    hold_nxt = 1'b0;
    case (ref_select_policy_r)
      `CDDDS_POLICY_AUTO: begin
        if (!ref_ok[active_ref_o]) begin
          if (ref_ok[(active_ref_o == 2'h2) ? 2'h0 : active_ref_o + 2'h1])
            ref_nxt = (active_ref_o == 2'h2) ? 2'h0 : active_ref_o + 2'h1;
          else if (ref_ok[(active_ref_o == 2'h0) ? 2'h2 : active_ref_o - 2'h1])
            ref_nxt = (active_ref_o == 2'h0) ? 2'h2 : active_ref_o - 2'h1;
          else
            hold_nxt = 1'b1;
        end
      end
      `CDDDS_POLICY_PIN: begin
        ref_nxt = (pin_sel == 2'h3) ? 2'h2 : pin_sel;
        // holdover on loss of the selected input
        hold_nxt = !ref_ok[ref_nxt];
      end
      default: begin
        ref_nxt  = (ref_manual_r == 2'h3) ? 2'h2 : ref_manual_r;
        hold_nxt = !ref_ok[ref_nxt];
      end
    endcase
  end

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_ref_o <= 2'h0;
      holdover_o   <= 1'b0;
    end else begin
      active_ref_o <= ref_nxt;
      holdover_o   <= hold_nxt;
    end
  end

  // vco selection drives distribution and loop feedback
  wire vco_clk = ext_vco_en ? ext_vco_i : vco_i[vco_selector];

  // two-stage resample of sync, then edge detect
  reg sync_m_r;
  reg sync_s_r;
  reg sync_d_r;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      sync_m_r <= sync_i;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end
  wire sync_ev = sync_en & sync_s_r & ~sync_d_r;

  // shared sysref divider with global delay stage
  reg  [12:0] sref_cnt_r;
  reg         sref_clk_r;
  reg  [12:0] sref_gdly_act_r;
  wire [12:0] sref_gdly_cfg = sref_dly_r[28:16];
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sref_cnt_r      <= 13'h0000;
      sref_clk_r      <= 1'b0;
      sref_gdly_act_r <= 13'h0000;
    end else if (sync_ev && !sref_sync_block) begin
      // staged global delay loads on sync as preload
      sref_gdly_act_r <= sref_gdly_cfg;
      sref_cnt_r      <= 13'h1FFF - sref_gdly_cfg;
      sref_clk_r      <= 1'b0;
    end else begin
      if (sref_cnt_r >= sref_div_r - 13'h0001) begin
        sref_cnt_r <= 13'h0000;
        sref_clk_r <= 1'b1;
      end else begin
        sref_cnt_r <= sref_cnt_r + 13'h0001;
        sref_clk_r <= (sref_cnt_r + 13'h0001) < (sref_div_r >> 1);
      end
    end
  end

  // per-channel device divider, delays and sysref
  reg  [5:0]  dcnt_r     [0:NCH-1];
  reg  [5:0]  ddly_act_r [0:NCH-1];
  reg  [10:0] sdly_sh_r  [0:NCH-1];
  reg  [NCH-1:0] dclk_raw;
  wire [5:0]  ddly_cfg = dclk_dly_r[5:0];
  wire [3:0]  sdly_cfg = sref_dly_r[3:0];
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      // sync reset gated by enable and block bit
      wire do_sync = sync_ev & ~divider_sync_block[gi];
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          dcnt_r[gi]     <= 6'h00;
          ddly_act_r[gi] <= `CDDDS_DDLY_MIN;
          dclk_raw[gi]   <= 1'b0;
          sdly_sh_r[gi]  <= 11'h000;
        end else begin
          if (do_sync) begin
            // common edge offset by fixed delay
            ddly_act_r[gi] <= ddly_cfg;
            dcnt_r[gi]     <= 6'h3F - ddly_cfg + 6'h01;
            dclk_raw[gi]   <= 1'b0;
          end else if (dyn_delay_mode && ddly_act_r[gi] != ddly_cfg
                       && dcnt_r[gi] == 6'h00) begin
            // dynamic mode: slip phase while running
            ddly_act_r[gi] <= ddly_cfg;
            dcnt_r[gi]     <= 6'h00;
          end else if (dcnt_r[gi] >= dclk_div_r - 6'h01
                       && dcnt_r[gi] < 6'h20) begin
            dcnt_r[gi]   <= 6'h00;
            dclk_raw[gi] <= 1'b1;
          end else begin
            dcnt_r[gi] <= dcnt_r[gi] + 6'h01;
            // half high, odd ratios one cycle shorter high than low
            if (dcnt_r[gi] < 6'h20)
              dclk_raw[gi] <= (dcnt_r[gi] + 6'h01) < (dclk_div_r >> 1)
                              || dclk_div_r == 6'h01;
          end
          sdly_sh_r[gi] <= {sdly_sh_r[gi][9:0], sref_clk_r};
        end
      end

      // with glitchless set, half step and analog taps update only on low output
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          half_step_o[gi]                 <= 1'b0;
          analog_delay_o[gi*5 +: 5]       <= 5'h00;
          analog_en_o[gi]                 <= 1'b0;
          sysref_analog_delay_o[gi*4 +: 4] <= 4'h0;
        end else if (!glitchless_en || !device_clock_output_o[gi]) begin
          half_step_o[gi] <= dclk_dly_r[8] ^ dclk_div_r[0];
          // 25 ps steps capped at 575 ps
          analog_delay_o[gi*5 +: 5] <= (dclk_dly_r[20:16] >
            `CDDDS_ADLY_MAX) ? `CDDDS_ADLY_MAX : dclk_dly_r[20:16];
          analog_en_o[gi] <= dclk_dly_r[21];
          // independent 150 ps sysref analog steps
          sysref_analog_delay_o[gi*4 +: 4] <= sref_dly_r[gi*4+4 +: 4];
        end
      end

      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          device_clock_output_o[gi] <= 1'b0;
          sysref_output_o[gi]       <= 1'b0;
        end else begin
          device_clock_output_o[gi] <= dclk_raw[gi];
          // device divider routed to paired sysref
          sysref_output_o[gi] <= dclk_to_sref[gi] ? dclk_raw[gi] :
            (sdly_cfg == 4'h0 ? sref_clk_r :
             sdly_sh_r[gi][(sdly_cfg > 4'hB ? 4'hB : sdly_cfg) - 4'h1]);
        end
      end
    end
  endgenerate

  // buffered osc output source, feedback select
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buffered_osc_output_o <= 1'b0;
      osc_output_format_o   <= 2'h0;
      vco_sel_o             <= 1'b0;
      dist_clk_o            <= 1'b0;
      loop_feedback_o       <= 1'b0;
    end else begin
      case (osc_output_source)
        2'h0:    buffered_osc_output_o <= second_loop_ref_input_i;
        2'h1:    buffered_osc_output_o <= dclk_raw[3];
        2'h2:    buffered_osc_output_o <= dclk_raw[4];
        default: buffered_osc_output_o <= sref_clk_r;
      endcase
      osc_output_format_o <= path_ctrl_r[17:16];
      vco_sel_o           <= vco_selector;
      dist_clk_o          <= vco_clk;
      if (!zero_delay_en)
        loop_feedback_o <= vco_clk;
      else begin
        case (feedback_selector)
          2'h0:    loop_feedback_o <= dclk_raw[3];
          2'h1:    loop_feedback_o <= dclk_raw[4];
          2'h2:    loop_feedback_o <= sref_clk_r;
          default: loop_feedback_o <= external_feedback_input_i;
        endcase
      end
    end
  end

  function st_mux;
    input [2:0] sel;
    input       rb;
    begin
      case (sel)
        `CDDDS_ST_LOS:      st_mux = |ref_los_i;
        `CDDDS_ST_REFSEL:   st_mux = active_ref_o[0];
        `CDDDS_ST_LOCK:     st_mux = lock1_i & lock2_i;
        `CDDDS_ST_LOCK2:    st_mux = lock2_i;
        `CDDDS_ST_DIVOUT:   st_mux = ref_div_out_o[0];
        `CDDDS_ST_RAIL:     st_mux = vtune_rail_i;
        `CDDDS_ST_READBACK: st_mux = rb;
        default:            st_mux = 1'b0;
      endcase
    end
  endfunction

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_pin_1_o <= 1'b0;
      status_pin_2_o <= 1'b0;
    end else begin
      status_pin_1_o <= st_mux(status_sel_r[2:0], holdover_o);
      status_pin_2_o <= st_mux(status_sel_r[5:3], lock2_i);
    end
  end

  // read mux
  always @* begin
    prdata = 32'h00000000;
    if (rd_en && addr_ok) begin
      case (paddr)
        `CDDDS_REF_CTRL:   prdata = {28'h0, ref_manual_r,
                                     ref_select_policy_r};
        `CDDDS_REF_DIV0:   prdata = {8'h00, ref_div_r[0]};
        `CDDDS_REF_DIV1:   prdata = {8'h00, ref_div_r[1]};
        `CDDDS_REF_DIV2:   prdata = {8'h00, ref_div_r[2]};
        `CDDDS_PATH_CTRL:  prdata = path_ctrl_r;
        `CDDDS_DCLK_DIV:   prdata = {26'h0, dclk_div_r};
        `CDDDS_DCLK_DLY:   prdata = dclk_dly_r;
        `CDDDS_SREF_DIV:   prdata = {19'h0, sref_div_r};
        `CDDDS_SREF_DLY:   prdata = sref_dly_r;
        `CDDDS_SYNC_CTRL:  prdata = sync_ctrl_r;
        `CDDDS_STATUS_SEL: prdata = {26'h0, status_sel_r};
        `CDDDS_STATUS:     prdata = {16'h0, ddly_act_r[0], ref_ok,
                                     ref1_taken, holdover_o,
                                     active_ref_o, lock2_i, lock1_i};
        default:           prdata = 32'h00000000;
      endcase
    end
  end

endmodule

// ### tb/cddds_core_monitor.sv
`timescale 1ns/10ps
`include "cddds_regs.vh"
module cddds_core_monitor #(
  parameter NCH = 7
) (
  // clock, reset and apb
  input wire logic             core_clk_i,
  input wire logic             nrst_i,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [31:0]      prdata,
  // reference side
  input wire logic [2:0]       ref_los_i,
  input wire logic             ref_select_pin_0_i,
  input wire logic             ref_select_pin_1_i,
  input wire logic             vtune_rail_i,
  input wire logic             sync_i,
  // outputs watched
  input wire logic [NCH-1:0]   device_clock_output_o,
  input wire logic [1:0]       active_ref_o,
  input wire logic             holdover_o,
  input wire logic             status_pin_1_o
);
  logic [1:0]     pol_r;
  logic           sen_r;
  logic [NCH-1:0] blk_r;
  logic [2:0]     st1_r;
  wire            bad = (paddr[1:0] != 2'h0) || (paddr > `CDDDS_STATUS);
  wire [1:0]      pins = {ref_select_pin_1_i, ref_select_pin_0_i};

  // shadow of the few control fields the properties depend on
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pol_r <= 2'h0;
      sen_r <= 1'h0;
      blk_r <= '0;
      st1_r <= 3'h0;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == `CDDDS_REF_CTRL) pol_r <= pwdata[1:0];
      if (paddr == `CDDDS_SYNC_CTRL) sen_r <= pwdata[0];
      if (paddr == `CDDDS_SYNC_CTRL) blk_r <= pwdata[NCH+1:2];
      if (paddr == `CDDDS_STATUS_SEL) st1_r <= pwdata[2:0];
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_bad_addr_err: assert property (psel && penable && bad |->
    pslverr && prdata == 32'h00000000) else $error("bad address accepted");
  a_good_addr_ok: assert property (psel && penable && !bad |-> !pslverr)
    else $error("good address refused");
  a_reset_quiet: assert property (disable iff (1'h0) !nrst_i |->
    device_clock_output_o == '0 && !holdover_o && !status_pin_1_o)
    else $error("output active in reset");
  a_sync_reload: assert property ($rose(sync_i) && sen_r |->
    ##[2:4] ((device_clock_output_o & ~blk_r) == '0))
    else $error("sync did not reload dividers");
  a_holdover_enter: assert property (
    (pol_r == `CDDDS_POLICY_AUTO && ref_los_i == 3'h7) [*3] |->
    ##[0:4] holdover_o) else $error("no holdover with all refs lost");
  a_holdover_leave: assert property (
    (pol_r == `CDDDS_POLICY_AUTO && ref_los_i == 3'h0) [*3] |->
    ##[0:4] !holdover_o) else $error("holdover kept with valid refs");
  a_auto_hold_ref: assert property (
    (pol_r == `CDDDS_POLICY_AUTO && !holdover_o && ref_los_i == 3'h0) [*4]
    |=> $stable(active_ref_o)) else $error("switched with no loss");
  a_pin_select: assert property (
    (pol_r == `CDDDS_POLICY_PIN && pins != 2'h3 && ref_los_i == 3'h0 &&
    $stable(pins)) [*3] |-> ##[0:3] active_ref_o == pins)
    else $error("select pins ignored");
  a_status_rail: assert property (
    (st1_r == `CDDDS_ST_RAIL && $stable(vtune_rail_i)) [*4] |->
    status_pin_1_o == vtune_rail_i) else $error("status pin wrong");
endmodule

bind cddds_core cddds_core_monitor #(.NCH(NCH)) cddds_core_monitor_inst (
  .core_clk_i            (core_clk_i),
  .nrst_i                (nrst_i),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .prdata                (prdata),
  .ref_los_i             (ref_los_i),
  .ref_select_pin_0_i    (ref_select_pin_0_i),
  .ref_select_pin_1_i    (ref_select_pin_1_i),
  .vtune_rail_i          (vtune_rail_i),
  .sync_i                (sync_i),
  .device_clock_output_o (device_clock_output_o),
  .active_ref_o          (active_ref_o),
  .holdover_o            (holdover_o),
  .status_pin_1_o        (status_pin_1_o)
);

// ### tb/cddds_conv_model.sv
`timescale 1ns/10ps
// converter side: only listens, so it measures phase lengths and
// edge times in core cycles for the bench to compare
module cddds_conv_model #(
  parameter NCH = 7
) (
  // clock and reset
  input wire logic           clk_i,
  input wire logic           nrst_i,
  // received clocks
  input wire logic [NCH-1:0] dclk_i,
  input wire logic [NCH-1:0] sref_i
);
  int             cyc;
  int             rise_cyc [NCH];
  int             run0;
  int             hi0;
  int             lo0;
  int             slast;
  int             sper0;
  logic [NCH-1:0] dprev;
  logic           sprev;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc   <= 0;
      run0  <= 0;
      dprev <= '0;
      sprev <= 1'h0;
    end else begin
      cyc   <= cyc + 1;
      dprev <= dclk_i;
      sprev <= sref_i[0];
      for (int i = 0; i < NCH; i++) begin
        if (dclk_i[i] && !dprev[i]) rise_cyc[i] <= cyc;
      end
      if (dclk_i[0] != dprev[0]) begin
        if (dprev[0]) hi0 <= run0;
        else lo0 <= run0;
        run0 <= 1;
      end else begin
        run0 <= run0 + 1;
      end
      if (sref_i[0] && !sprev) begin
        sper0 <= cyc - slast;
        slast <= cyc;
      end
    end
  end
endmodule

// ### tb/clock_distribution_divide_delay_sync_test.sv
`timescale 1ns/10ps
`include "cddds_regs.vh"
module clock_distribution_divide_delay_sync_test;
  localparam NCH = 7;
  logic            core_clk_i;
  logic            nrst_i;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  wire             pready;
  wire             pslverr;
  wire [31:0]      prdata;
  logic [2:0]      ref_los_i;
  logic [1:0]      pins;
  logic            lock2_i;
  logic            vtune_rail_i;
  logic            sync_i;
  logic [7:0]      cnt = 8'h00;
  wire [NCH-1:0]   dco;
  wire [NCH-1:0]   sro;
  wire [1:0]       act;
  wire             hold;
  wire             st1;
  wire             st2;
  wire             vsel;
  logic [31:0]     rd_d;
  logic            rd_e;
  int              n_mismatch = 0;
  int              tests_run = 0;
  int              d4;
  int              d32;
  int              div_t [3] = '{2, 7, 32};

  cddds_core #(.NCH(NCH)) cddds_core_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ref_input_i(cnt[2:0]), .ref_los_i(ref_los_i),
    .ref_select_pin_0_i(pins[0]), .ref_select_pin_1_i(pins[1]),
    .lock1_i(cnt[4]), .lock2_i(lock2_i), .vtune_rail_i(vtune_rail_i),
    .second_loop_ref_input_i(cnt[1]), .external_feedback_input_i(cnt[2]),
    .vco_i(cnt[1:0]), .ext_vco_i(cnt[3]), .sync_i(sync_i),
    .device_clock_output_o(dco), .sysref_output_o(sro), .half_step_o(),
    .analog_delay_o(), .analog_en_o(), .sysref_analog_delay_o(),
    .buffered_osc_output_o(), .osc_output_format_o(), .vco_sel_o(vsel),
    .dist_clk_o(), .loop_feedback_o(), .ref_div_out_o(),
    .active_ref_o(act), .holdover_o(hold), .status_pin_1_o(st1),
    .status_pin_2_o(st2));

  cddds_conv_model #(.NCH(NCH)) cddds_conv_model_inst (
    .clk_i(core_clk_i), .nrst_i(nrst_i), .dclk_i(dco), .sref_i(sro));

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // free-running stimulus on the clock-like inputs
  always @(posedge core_clk_i) cnt <= cnt + 8'h01;

  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      n_mismatch++;
      $display("Error %0t: bus timeout", $time);
      end_of_test;
    end
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk_i);
  endtask

  task idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // cycles from raising sync until the first reloaded rise of channel 0
  task sync_meas(output int d);
    logic low;
    d = 0;
    low = 1'h0;
    sync_i <= 1'h1;
    while (d < 300 && !(low && dco[0] === 1'h1)) begin
      @(posedge core_clk_i);
      d++;
      if (d == 6) sync_i <= 1'h0;
      if (d >= 5 && dco[0] === 1'h0) low = 1'h1;
    end
    if (d < 6) sync_i <= 1'h0;
    if (d >= 300) begin
      n_mismatch++;
      $display("Error %0t: no reloaded edge", $time);
      end_of_test;
    end
    idle(2);
  endtask

  initial begin
    nrst_i = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ref_los_i = 3'h0;
    pins = 2'h0;
    lock2_i = 1'h0;
    vtune_rail_i = 1'h0;
    sync_i = 1'h0;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    @(posedge core_clk_i);
    apb(12'h030, 1'h0, 32'h0);
    chk(rd_e, 32'h1);
    chk(rd_d, 32'h0);
    apb(12'h006, 1'h0, 32'h0);
    chk(rd_e, 32'h1);
    apb(`CDDDS_DCLK_DIV, 1'h1, 32'h7);
    apb(`CDDDS_DCLK_DIV, 1'h0, 32'h0);
    chk(rd_d, 32'h7);
    chk(rd_e, 32'h0);
    apb(`CDDDS_REF_CTRL, 1'h1, {30'h0, `CDDDS_POLICY_AUTO});
    ref_los_i <= 3'h1;
    idle(8);
    chk(act, 32'h1);
    ref_los_i <= 3'h3;
    idle(8);
    chk(act, 32'h2);
    ref_los_i <= 3'h7;
    idle(8);
    chk(hold, 32'h1);
    ref_los_i <= 3'h0;
    idle(8);
    chk(hold, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(`CDDDS_REF_CTRL, 1'h1, {28'h0, i[1:0], 2'h0});
      idle(6);
      chk(act, i);
    end
    apb(`CDDDS_REF_CTRL, 1'h1, {30'h0, `CDDDS_POLICY_PIN});
    for (int i = 0; i < 3; i++) begin
      pins <= i[1:0];
      idle(6);
      chk(act, i);
    end
    apb(`CDDDS_STATUS_SEL, 1'h1, {26'h0, `CDDDS_ST_LOCK2, `CDDDS_ST_RAIL});
    for (int i = 0; i < 2; i++) begin
      vtune_rail_i <= i[0];
      lock2_i <= ~i[0];
      idle(6);
      chk({st2, st1}, {30'h0, ~i[0], i[0]});
    end
    apb(`CDDDS_PATH_CTRL, 1'h1, 32'h4);
    idle(6);
    chk(vsel, 32'h1);
    // sync enabled, channel 1 kept out of it
    apb(`CDDDS_SYNC_CTRL, 1'h1, 32'h9);
    apb(`CDDDS_DCLK_DLY, 1'h1, 32'h4);
    foreach (div_t[k]) begin
      apb(`CDDDS_DCLK_DIV, 1'h1, div_t[k]);
      sync_meas(d4);
      idle(3 * div_t[k] + 4);
      chk(cddds_conv_model_inst.hi0 + cddds_conv_model_inst.lo0,
          div_t[k]);
      if (div_t[k] % 2 == 0) chk(cddds_conv_model_inst.hi0, div_t[k] / 2);
      chk(cddds_conv_model_inst.rise_cyc[2],
          cddds_conv_model_inst.rise_cyc[0]);
    end
    apb(`CDDDS_DCLK_DIV, 1'h1, 32'h2);
    sync_meas(d4);
    apb(`CDDDS_DCLK_DLY, 1'h1, 32'h20);
    sync_meas(d32);
    chk(d32 - d4, 32'h1C);
    apb(`CDDDS_SREF_DIV, 1'h1, 32'h8);
    idle(40);
    chk(cddds_conv_model_inst.sper0, 32'h8);
    apb(`CDDDS_SREF_DIV, 1'h1, 32'hB);
    idle(50);
    chk(cddds_conv_model_inst.sper0, 32'hB);
    end_of_test;
  end
endmodule
